/* src/dcsr_pkg.sv */
// Shared constants for the chained serial readout link
package dcsr_pkg;
    // Frame layout
    localparam int STAT_W = 24;
    localparam int CH_N = 8;
    localparam int CH_W_HI = 24;
    localparam int CH_W_LO = 16;
    localparam int FRAME_W = STAT_W + CH_N * CH_W_HI;
    localparam int LEN_HI = FRAME_W;
    localparam int LEN_LO = STAT_W + CH_N * CH_W_LO;
    // One extra slot carries the don't-care bit between frames
    localparam int SR_W = FRAME_W + 1;
    localparam int INS_HI = SR_W - 1 - LEN_HI;
    localparam int INS_LO = SR_W - 1 - LEN_LO;
    // Command word: opcode byte then argument byte, MSB first
    localparam int CMD_W = 16;
    localparam int CNT_W = 8;
    localparam int NBIT_W = 12;
    localparam logic [7:0] CMD_WRCFG = 8'h41;
    localparam logic [7:0] CMD_START = 8'h08;
    // first_config_reg layout and reset value
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_CHAIN_BIT = 6;
    localparam int CFG_OSC_BIT = 5;
    localparam int CFG_RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_LORES_MIN = 3'h5;
    // Status word byte that mirrors first_config_reg
    localparam int STAT_CFG_LSB = 0;

    // Resolution implied by rate_select: high codes give 16-bit words
    function automatic logic dcsr_lores(input logic [7:0] cfg);
        return cfg[CFG_RATE_LSB +: RATE_W] >= RATE_LORES_MIN;
    endfunction
endpackage

/* src/dcsr_if.sv */
// Serial chain link between host controller and one converter
`timescale 1ns/1ns
`default_nettype none
interface dcsr_if;
    logic sclk;
    logic din;
    logic cs_n;
    logic dout_o;
    logic dout_oe_n;
    logic daisy_in;
    logic dout;

    // Undriven line reads low; the bench may join several ends itself
    assign dout = dout_oe_n ? 1'b0 : dout_o;

    modport host (output sclk, output din, output cs_n, input dout);
    modport device (input sclk, input din, input cs_n, input daisy_in, output dout_o, output dout_oe_n);
endinterface
`default_nettype wire

/* src/dcsr_device.sv */
// Converter end of the chained serial readout link
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Forward chain input only when chain bit set
// - Host drives shared clock, data-in, select
// - Chain input takes next device's serial output
// - Own frame, one don't-care, then forwarded frames
// - Chain mode forbids oscillator output; external clock
// - Host adds one clock between device frames
// - Shared select makes every write identical
// - Readback trusted only from nearest device
// - Frame is status plus eight channel words
// - Channel word width follows rate_select
// - Host limits chain length to clock budget
// - Retiming flop on inverted clock at chain input
// - Start may come as serial command
// - Output released while select is high
// - Oscillator on clock pin only when enabled
module dcsr_device
    import dcsr_pkg::*;
#(
    parameter int OSC_HALF = 2
)
(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    dcsr_if.device LINK,
    input wire logic START_PIN,
    input wire logic FRAME_VALID,
    input wire logic [STAT_W-1:0] FRAME_STATUS,
    input wire logic [CH_N*CH_W_HI-1:0] FRAME_CH,
    output logic FRAME_BUSY,
    output logic CONV_START,
    output logic CLK_OUT,
    output logic CHAIN_ON
);

    // Left-align status and channel words; the config byte rides in the status word
    function automatic logic [SR_W-1:0] pack_frame(
        input logic [FRAME_W-1:0] f,
        input logic [7:0] cfg,
        input logic lores
    );
        logic [SR_W-1:0] r;
        r = '0;
        r[SR_W-1 -: STAT_W] = f[FRAME_W-1 -: STAT_W];
        r[SR_W-STAT_W+STAT_CFG_LSB +: 8] = cfg;
        for (int i = 0; i < CH_N; i++) begin
            if (lores) begin
                r[SR_W-1-STAT_W-i*CH_W_LO -: CH_W_LO] = f[FRAME_W-1-STAT_W-i*CH_W_HI -: CH_W_LO];
            end else begin
                r[SR_W-1-STAT_W-i*CH_W_HI -: CH_W_HI] = f[FRAME_W-1-STAT_W-i*CH_W_HI -: CH_W_HI];
            end
        end
        return r;
    endfunction

    // ---------------- System clock side ----------------
    logic [FRAME_W-1:0] hold_q, hold_d;
    logic req_q, req_d;
    logic busy_q, busy_d;
    logic ack_s1_q, ack_s2_q;
    logic chain_s1_q, chain_s2_q;
    logic osc_s1_q, osc_s2_q;
    logic stt_s1_q, stt_s2_q, stt_s3_q;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic conv_q, conv_d;
    logic clk_out_q, clk_out_d;
    logic [7:0] osc_cnt_q, osc_cnt_d;

    // ---------------- Link clock side ----------------
    logic [SR_W-1:0] sr_q, sr_d;
    logic [FRAME_W-1:0] frame_q, frame_d;
    logic [7:0] cfg_q, cfg_d;
    logic [CMD_W-2:0] dsr_q, dsr_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic lores_q, lores_d;
    logic ack_q, ack_d;
    logic stt_tgl_q, stt_tgl_d;
    logic req_s1_q, req_s2_q;
    logic daisy_q;
    logic oe_n_q;
    logic [CMD_W-1:0] cmd_word;
    logic new_frame;

    // Capture a frame only when the link side has taken the previous one
    always_comb begin
        hold_d = hold_q;
        req_d = req_q;
        if (FRAME_VALID && !busy_q) begin
            hold_d = {FRAME_STATUS, FRAME_CH};
            req_d = ~req_q;
        end
        // Only the second synchroniser stage may be read; the first can still be settling
        busy_d = req_d ^ ack_s2_q;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            hold_q <= '0;
            req_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            req_q <= req_d;
            busy_q <= busy_d;
        end
    end

    // Two-flop synchronisers for link-side levels and toggles and for the start pin
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            chain_s1_q <= 1'b0;
            chain_s2_q <= 1'b0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            stt_s1_q <= 1'b0;
            stt_s2_q <= 1'b0;
            stt_s3_q <= 1'b0;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            chain_s1_q <= cfg_q[CFG_CHAIN_BIT];
            chain_s2_q <= chain_s1_q;
            osc_s1_q <= cfg_q[CFG_OSC_BIT];
            osc_s2_q <= osc_s1_q;
            stt_s1_q <= stt_tgl_q;
            stt_s2_q <= stt_s1_q;
            stt_s3_q <= stt_s2_q;
            pin_s1_q <= START_PIN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Conversion start from the pin edge or the serial command; oscillator stand-in on the clock pin
    always_comb begin
        conv_d = (stt_s2_q ^ stt_s3_q) | (pin_s2_q & ~pin_s3_q);
        osc_cnt_d = osc_cnt_q;
        clk_out_d = 1'b0;
        if (osc_s2_q && !chain_s2_q) begin
            clk_out_d = clk_out_q;
            osc_cnt_d = osc_cnt_q + 8'h01;
            if (osc_cnt_q == 8'(OSC_HALF - 1)) begin
                osc_cnt_d = 8'h00;
                clk_out_d = ~clk_out_q;
            end
        end else begin
            osc_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            conv_q <= 1'b0;
            clk_out_q <= 1'b0;
            osc_cnt_q <= 8'h00;
        end else begin
            conv_q <= conv_d;
            clk_out_q <= clk_out_d;
            osc_cnt_q <= osc_cnt_d;
        end
    end

    assign FRAME_BUSY = busy_q;
    assign CONV_START = conv_q;
    assign CLK_OUT = clk_out_q;
    assign CHAIN_ON = chain_s2_q;

    // Frame request seen on the link clock; it only advances while the host clocks
    always_ff @(posedge LINK.sclk or negedge RESETN) begin
        if (!RESETN) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Sample the downstream output half a clock after it changes, for hold margin
    always_ff @(negedge LINK.sclk or negedge RESETN) begin
        if (!RESETN) begin
            daisy_q <= 1'b0;
        end else begin
            daisy_q <= LINK.daisy_in;
        end
    end

    assign new_frame = req_s2_q != ack_q;
    assign cmd_word = {dsr_q, LINK.din};

    // Shift engine: load own frame on the first edge, then shift with chain bits entering behind it
    always_comb begin
        sr_d = sr_q;
        frame_d = frame_q;
        ack_d = ack_q;
        lores_d = lores_q;
        cfg_d = cfg_q;
        dsr_d = dsr_q;
        stt_tgl_d = stt_tgl_q;
        cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 8'h01;
        if (cnt_q == '0) begin
            // The held frame is stable here because the system side waits for the ack
            if (new_frame) begin
                frame_d = hold_q;
                ack_d = ~ack_q;
            end
            lores_d = dcsr_lores(cfg_q);
            sr_d = pack_frame(new_frame ? hold_q : frame_q, cfg_q, dcsr_lores(cfg_q));
        end else begin
            for (int j = SR_W - 1; j > 0; j--) begin
                sr_d[j] = sr_q[j-1];
            end
            sr_d[0] = 1'b0;
            // Insertion point makes chain data follow exactly one don't-care bit
            sr_d[lores_q ? INS_LO : INS_HI] = cfg_q[CFG_CHAIN_BIT] ? daisy_q : 1'b0;
        end
        // Command word arrives on the first sixteen clocks of every selection
        if (cnt_q < CNT_W'(CMD_W)) begin
            dsr_d = cmd_word[CMD_W-2:0];
        end
        if (cnt_q == CNT_W'(CMD_W - 1)) begin
            if (cmd_word[CMD_W-1 -: 8] == CMD_WRCFG) begin
                cfg_d = cmd_word[7:0];
            end
            if (cmd_word[CMD_W-1 -: 8] == CMD_START) begin
                stt_tgl_d = ~stt_tgl_q;
            end
        end
    end

    always_ff @(posedge LINK.sclk or negedge RESETN) begin
        if (!RESETN) begin
            sr_q <= '0;
            frame_q <= '0;
            ack_q <= 1'b0;
            lores_q <= 1'b0;
            cfg_q <= CFG_RESET;
            dsr_q <= '0;
            stt_tgl_q <= 1'b0;
        end else begin
            sr_q <= sr_d;
            frame_q <= frame_d;
            ack_q <= ack_d;
            lores_q <= lores_d;
            cfg_q <= cfg_d;
            dsr_q <= dsr_d;
            stt_tgl_q <= stt_tgl_d;
        end
    end

    // Bit counter restarts with every selection, without needing a clock edge
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Release the line at once when deselected so a neighbour can drive it
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n or negedge RESETN) begin
        if (!RESETN) begin
            oe_n_q <= 1'b1;
        end else if (LINK.cs_n) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= 1'b0;
        end
    end

    assign LINK.dout_o = sr_q[SR_W-1];
    assign LINK.dout_oe_n = oe_n_q;

endmodule
`default_nettype wire

/* src/dcsr_host.sv */
// Host controller end of the chained serial readout link
`timescale 1ns/1ns
`default_nettype none
module dcsr_host
    import dcsr_pkg::*;
#(
    parameter int SCLK_HALF = 4,
    parameter int MAX_DEV = 6
)
(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    dcsr_if.host LINK,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OP,
    input wire logic [7:0] CMD_ARG,
    input wire logic [3:0] CMD_NDEV,
    output logic CMD_READY,
    output logic RX_VALID,
    output logic RX_BIT,
    output logic [7:0] RD_CFG,
    output logic DONE
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b011,
        ST_HOLD = 3'b100
    } dcsr_hst_t;

    dcsr_hst_t st_q, st_d;
    logic [7:0] div_q, div_d;
    logic [NBIT_W-1:0] bit_q, bit_d;
    logic [NBIT_W-1:0] nbits_q, nbits_d;
    logic [CMD_W-1:0] word_q, word_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] rdcfg_q, rdcfg_d;
    logic sclk_q, sclk_d;
    logic cs_n_q, cs_n_d;
    logic din_q, din_d;
    logic rxv_q, rxv_d;
    logic rxb_q, rxb_d;
    logic done_q, done_d;
    logic rdy_q, rdy_d;
    logic dout_s1_q, dout_s2_q;
    logic [3:0] ndev;
    logic [NBIT_W-1:0] flen;
    logic half_done;

    // Device count clamped so the whole chain fits the clock budget
    assign ndev = (CMD_NDEV == 4'h0) ? 4'h1 : (CMD_NDEV > 4'(MAX_DEV)) ? 4'(MAX_DEV) : CMD_NDEV;
    // Each device slot is its frame plus one extra clock
    assign flen = NBIT_W'(dcsr_lores(cfg_q) ? LEN_LO + 1 : LEN_HI + 1);
    assign half_done = div_q == 8'(SCLK_HALF - 1);

    // Line level from the devices, brought into this clock first
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            dout_s1_q <= 1'b0;
            dout_s2_q <= 1'b0;
        end else begin
            dout_s1_q <= LINK.dout;
            dout_s2_q <= dout_s1_q;
        end
    end

    // Transfer sequencer; the serial clock is a divided system clock
    always_comb begin
        st_d = st_q;
        div_d = half_done ? 8'h00 : div_q + 8'h01;
        bit_d = bit_q;
        nbits_d = nbits_q;
        word_d = word_q;
        cfg_d = cfg_q;
        rdcfg_d = rdcfg_q;
        sclk_d = sclk_q;
        cs_n_d = cs_n_q;
        din_d = din_q;
        rxv_d = 1'b0;
        rxb_d = rxb_q;
        done_d = 1'b0;
        rdy_d = rdy_q;
        case (st_q)
            ST_IDLE: begin
                div_d = 8'h00;
                if (CMD_VALID) begin
                    // Length uses the setting in force when the frame loads
                    nbits_d = NBIT_W'(ndev) * flen;
                    word_d = {CMD_OP, CMD_ARG};
                    din_d = CMD_OP[7];
                    cs_n_d = 1'b0;
                    bit_d = '0;
                    rdy_d = 1'b0;
                    if (CMD_OP == CMD_WRCFG) begin
                        cfg_d = CMD_ARG;
                    end
                    st_d = ST_SETUP;
                end
            end
            ST_SETUP, ST_LOW: begin
                if (half_done) begin
                    sclk_d = 1'b1;
                    st_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (half_done) begin
                    sclk_d = 1'b0;
                    rxv_d = 1'b1;
                    rxb_d = dout_s2_q;
                    // Config echo is only meaningful from the nearest device
                    if (bit_q >= NBIT_W'(STAT_W - 8) && bit_q < NBIT_W'(STAT_W)) begin
                        rdcfg_d = {rdcfg_q[6:0], dout_s2_q};
                    end
                    word_d = {word_q[CMD_W-2:0], 1'b0};
                    din_d = word_q[CMD_W-2];
                    bit_d = bit_q + 12'h001;
                    st_d = (bit_q + 12'h001 == nbits_q) ? ST_HOLD : ST_LOW;
                end
            end
            ST_HOLD: begin
                if (half_done) begin
                    cs_n_d = 1'b1;
                    din_d = 1'b0;
                    done_d = 1'b1;
                    rdy_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= ST_IDLE;
            div_q <= 8'h00;
            bit_q <= '0;
            nbits_q <= '0;
            word_q <= '0;
            cfg_q <= CFG_RESET;
            rdcfg_q <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            din_q <= 1'b0;
            rxv_q <= 1'b0;
            rxb_q <= 1'b0;
            done_q <= 1'b0;
            rdy_q <= 1'b1;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            nbits_q <= nbits_d;
            word_q <= word_d;
            cfg_q <= cfg_d;
            rdcfg_q <= rdcfg_d;
            sclk_q <= sclk_d;
            cs_n_q <= cs_n_d;
            din_q <= din_d;
            rxv_q <= rxv_d;
            rxb_q <= rxb_d;
            done_q <= done_d;
            rdy_q <= rdy_d;
        end
    end

    // Clock, data and select are shared by every device on the chain
    assign LINK.sclk = sclk_q;
    assign LINK.din = din_q;
    assign LINK.cs_n = cs_n_q;
    assign CMD_READY = rdy_q;
    assign RX_VALID = rxv_q;
    assign RX_BIT = rxb_q;
    assign RD_CFG = rdcfg_q;
    assign DONE = done_q;

endmodule
`default_nettype wire

/* test/dcsr_assertions.sv */
// Concurrent checks on the link wires nearest the host
`timescale 1ns/1ns
`default_nettype none
module dcsr_assertions #(
    parameter int SCLK_HALF = 4
)
(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic sclk,
    input wire logic din,
    input wire logic cs_n,
    input wire logic dout_o,
    input wire logic dout_oe_n
);
    // The host makes clock, data-in and select from the system clock and the device output moves on them, so one domain covers them
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    // Deselected device lets go of the shared line
    property p_release;
        cs_n |-> dout_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("data line driven while deselected");

    // Selected device drives from the first clock rise
    property p_drive;
        $rose(sclk) && !cs_n |-> !dout_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("data line not driven after clock rise");

    // Shared clock rests low outside a selection
    property p_sclk_idle;
        cs_n |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock moves while deselected");

    // High phase lasts exactly one half period
    property p_sclk_high;
        $fell(sclk) |-> $past(sclk, SCLK_HALF) && !$past(sclk, SCLK_HALF + 1);
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase wrong");

    // Select leads the first rise by one half period
    property p_lead;
        $fell(cs_n) |-> !sclk [*4] ##1 sclk;
    endproperty
    a_lead: assert property (p_lead) else $error("first clock rise misplaced after select");

    // Select returns one half period after the last fall
    property p_tail;
        $rose(cs_n) |-> $past(sclk, SCLK_HALF + 1) && !$past(sclk, SCLK_HALF);
    endproperty
    a_tail: assert property (p_tail) else $error("select released at wrong time");

    // Output bits only move with a clock rise, one bit per clock
    property p_dout_move;
        !cs_n && !$past(cs_n) && $changed(dout_o) |-> $rose(sclk);
    endproperty
    a_dout_move: assert property (p_dout_move) else $error("data out changed off a clock rise");

    // Command data only moves at a clock fall or at select
    property p_din_move;
        !cs_n && $changed(din) |-> $fell(sclk) || $fell(cs_n);
    endproperty
    a_din_move: assert property (p_din_move) else $error("data in changed off a clock fall");
endmodule
`default_nettype wire

/* test/dcsr_tb.sv */
// Bench for the host joined to two chained converter ends
`timescale 1ns/1ns
`default_nettype none
module dcsr_daisy_chain_serial_readout_tb import dcsr_pkg::*;;
    localparam int SH = 4;
    localparam int NDEV_MAX = 6;
    // Each step: opcode, argument, device count; config goes round every rate and mode
    localparam logic [19:0] STEPS [11] = '{20'h41402, 20'h41452, 20'h08002, 20'h41073, 20'h41201,
        20'h41640, 20'h4146f, 20'h41412, 20'h41432, 20'h41422, 20'h41402};
    logic clk_sys;
    logic resetn;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [7:0] cmd_arg;
    logic [3:0] cmd_ndev;
    logic cmd_ready;
    logic rx_valid;
    logic rx_bit;
    logic [7:0] rd_cfg;
    logic done;
    logic start_pin;
    logic fvalid;
    logic [STAT_W-1:0] fstat [2];
    logic [CH_N*CH_W_HI-1:0] fch [2];
    logic [1:0] conv;
    logic [1:0] clko;
    logic [1:0] clko_p;
    logic [1:0] chon;
    logic [1:0] fbusy;
    logic [7:0] cfg;
    logic [31:0] seed;
    logic rxq [$];
    int conv_cnt [2];
    int osc_cnt;
    int err_count;
    int n_tests;

    dcsr_if lk [2] ();
    // Shared clock, data-in and select; device 1 feeds device 0, its own chain input grounded
    assign lk[1].sclk = lk[0].sclk;
    assign lk[1].din = lk[0].din;
    assign lk[1].cs_n = lk[0].cs_n;
    // Direct chain wiring; the device retimes on the falling clock itself
    assign lk[0].daisy_in = lk[1].dout;
    assign lk[1].daisy_in = 1'b0;

    dcsr_host #(.SCLK_HALF(SH), .MAX_DEV(NDEV_MAX)) i_dcsr_host (.CLK_SYS(clk_sys), .RESETN(resetn),
        .LINK(lk[0].host), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ARG(cmd_arg), .CMD_NDEV(cmd_ndev),
        .CMD_READY(cmd_ready), .RX_VALID(rx_valid), .RX_BIT(rx_bit), .RD_CFG(rd_cfg), .DONE(done));
    for (genvar d = 0; d < 2; d++) begin : g_dev
        dcsr_device i_dcsr_device (.CLK_SYS(clk_sys), .RESETN(resetn), .LINK(lk[d].device),
            .START_PIN(start_pin), .FRAME_VALID(fvalid), .FRAME_STATUS(fstat[d]), .FRAME_CH(fch[d]),
            .FRAME_BUSY(fbusy[d]), .CONV_START(conv[d]), .CLK_OUT(clko[d]), .CHAIN_ON(chon[d]));
    end
    dcsr_assertions #(.SCLK_HALF(SH)) i_dcsr_assertions (.CLK_SYS(clk_sys), .RESETN(resetn),
        .sclk(lk[0].sclk), .din(lk[0].din), .cs_n(lk[0].cs_n), .dout_o(lk[0].dout_o),
        .dout_oe_n(lk[0].dout_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Own frame bit k: status with config echo in its low byte, then channel words
    function automatic logic own_bit(input int d, input int k, input logic [7:0] c);
        int w;
        w = (c[2:0] >= 3'h5) ? 16 : 24;
        if (k < 16) return fstat[d][23-k];
        if (k < 24) return c[23-k];
        return fch[d][191 - 24 * ((k - 24) / w) - (k - 24) % w];
    endfunction

    // Expected link bit; 2 marks the don't-care slot. A config write lands after the
    // command word, so forwarded bits from index 15 on follow the new chain bit
    function automatic int exp_bit(input int d, input int p, input logic [7:0] c, input logic ch_new);
        int len;
        len = 24 + 8 * ((c[2:0] >= 3'h5) ? 16 : 24);
        if (p < len) return int'(own_bit(d, p, c));
        if (p == len) return 2;
        if (d == 1 || !((p - len - 1 < CMD_W - 1) ? c[6] : ch_new)) return 0;
        return exp_bit(1, p - len - 1, c, ch_new);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Monitors sample at the falling edge, well clear of the launching edge
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_bit);
        end
        for (int d = 0; d < 2; d++) begin
            if (conv[d] === 1'b1) begin
                conv_cnt[d]++;
            end
        end
        if (clko !== clko_p) begin
            osc_cnt++;
        end
        clko_p = clko;
    end

    // One whole command; the frame of the first one may predate the offered frame
    task automatic xfer(input logic [19:0] s, input logic bits);
        int ne;
        int len;
        int e;
        int o0;
        logic nch;
        ne = (s[3:0] == 0) ? 1 : ((s[3:0] > NDEV_MAX) ? NDEV_MAX : s[3:0]);
        len = 24 + 8 * ((cfg[2:0] >= 3'h5) ? 16 : 24);
        nch = (s[19:12] == CMD_WRCFG) ? s[10] : cfg[6];
        rxq = {};
        do @(negedge clk_sys); while (cmd_ready !== 1'b1);
        @(posedge clk_sys);
        cmd_op <= s[19:12];
        cmd_arg <= s[11:4];
        cmd_ndev <= s[3:0];
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        do @(negedge clk_sys); while (done !== 1'b1);
        chk("bit count", ne * (len + 1), rxq.size());
        chk("config echo", cfg, rd_cfg);
        for (int p = 0; p < rxq.size() && bits; p++) begin
            e = exp_bit(0, p, cfg, nch);
            if (e != 2) chk("serial bit", e, rxq[p]);
        end
        if (s[19:12] == CMD_WRCFG) cfg = s[11:4];
        o0 = osc_cnt;
        repeat (40) @(negedge clk_sys);
        chk("oscillator output", cfg[5] && !cfg[6], osc_cnt != o0);
        chk("chain enable", {2{cfg[6]}}, chon);
    endtask

    // Timeout sized well above the longest command mix
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        seed = 32'h35;
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_arg = 8'h00;
        cmd_ndev = 4'h0;
        start_pin = 1'b0;
        fvalid = 1'b0;
        cfg = CFG_RESET;
        // Random frames are fixed for the run so every selection after the first repeats them
        for (int d = 0; d < 2; d++) begin
            fstat[d] = STAT_W'(rnd());
            for (int i = 0; i < 6; i++) fch[d][i*32 +: 32] = rnd();
        end
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        fvalid <= 1'b1;
        for (int i = 0; i < 11; i++) xfer(STEPS[i], i > 0);
        // Frame offer stays up, so each end has taken a fresh frame the link has not loaded yet
        chk("frame busy", 2'b11, fbusy);
        @(posedge clk_sys);
        start_pin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        start_pin <= 1'b0;
        repeat (10) @(negedge clk_sys);
        chk("start pulses dev0", 2, conv_cnt[0]);
        chk("start pulses dev1", 2, conv_cnt[1]);
        finish_test();
    end
endmodule
`default_nettype wire
